// file: acf_pkg.sv
package acf_pkg;
  // Clock and conversion timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CLK_NS       = 20;
  localparam int unsigned CONV_TIME_NS = 5000;
  localparam int unsigned CONV_CYC     = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  // Timebase rates and their divisors from the bus clock
  localparam int unsigned TB_5M_HZ   = 5_000_000;
  localparam int unsigned TB_1M_HZ   = 1_000_000;
  localparam int unsigned TB_100K_HZ = 100_000;
  localparam int unsigned TB_10K_HZ  = 10_000;
  localparam int unsigned TB_1K_HZ   = 1_000;
  localparam int unsigned TB_100_HZ  = 100;
  localparam int unsigned DIV_5M     = CLK_HZ / TB_5M_HZ;
  localparam int unsigned DIV_1M     = CLK_HZ / TB_1M_HZ;
  localparam int unsigned DIV_100K   = CLK_HZ / TB_100K_HZ;
  localparam int unsigned DIV_10K    = CLK_HZ / TB_10K_HZ;
  localparam int unsigned DIV_1K     = CLK_HZ / TB_1K_HZ;
  localparam int unsigned DIV_100    = CLK_HZ / TB_100_HZ;
  // Source codes in bits 11:8 of the interval mode word
  localparam logic [3:0] SRC_5M   = 4'h2;
  localparam logic [3:0] SRC_1M   = 4'hB;
  localparam logic [3:0] SRC_100K = 4'hC;
  localparam logic [3:0] SRC_10K  = 4'hD;
  localparam logic [3:0] SRC_1K   = 4'hE;
  localparam logic [3:0] SRC_100  = 4'hF;
  localparam logic [3:0] SRC_EXT  = 4'h5;
  localparam int unsigned SRC_LO  = 8;
  // Sizes
  localparam int unsigned RES_W      = 12;
  localparam int unsigned FIFO_DEPTH = 256;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_FIFO      = 8'h08;
  localparam logic [7:0] OFS_SOFT_CONV = 8'h0C;
  localparam logic [7:0] OFS_CLEAR     = 8'h10;
  localparam logic [7:0] OFS_CHG_ENTRY = 8'h14;
  localparam logic [7:0] OFS_CHG_LOAD  = 8'h18;
  localparam logic [7:0] OFS_CHG_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_ACQ_START = 8'h20;
  localparam logic [7:0] OFS_IV_MODE   = 8'h24;
  localparam logic [7:0] OFS_IV_LOAD   = 8'h28;
  localparam logic [7:0] OFS_SAMP_CNT  = 8'h2C;
  // Field positions
  localparam int unsigned CTRL_UNIP     = 0;
  localparam int unsigned CTRL_ACQ_EN   = 1;
  localparam int unsigned CTRL_CNT32    = 2;
  localparam int unsigned CTRL_EXT_PACE = 3;
  localparam int unsigned STS_DONE      = 8;
  localparam int unsigned STS_BUSY      = 9;
  localparam int unsigned STS_RUN       = 10;
  localparam int unsigned STS_NOT_EMPTY = 13;
  localparam int unsigned STS_OVFL_N    = 14;
  localparam int unsigned STS_OVRN_N    = 15;
  localparam int unsigned CHG_CHAN_LO   = 4;
  localparam int unsigned CHG_GAIN_LO   = 1;
  // Reset values
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [15:0] IV_MODE_RST = 16'h8225;
  localparam logic [15:0] IV_LOAD_RST = 16'h0002;
  localparam logic [31:0] SAMP_RST    = 32'h0000_0002;
  // Shared state encodings
  typedef enum logic [0:0] {CV_IDLE = 1'b0, CV_BUSY = 1'b1} acf_cv_t;
  typedef enum logic [0:0] {AQ_IDLE = 1'b0, AQ_RUN = 1'b1} acf_aq_t;
endpackage

// file: acf_if.sv
`timescale 1ns/10ps
interface acf_if;
  import acf_pkg::*;
  logic             start;   // Conversion request pulse
  logic             busy;    // Conversion in progress
  logic             done;    // Result ready pulse
  logic             ovrn;    // Start refused while busy
  logic [RES_W-1:0] result;  // Raw converter word
  logic             pop;     // Remove head entry
  logic             clear;   // Flush all entries
  logic             full;    // No room left
  logic             nempty;  // At least one entry
  logic             ovfl;    // Result dropped on full
  logic [RES_W-1:0] head;    // Oldest entry
  modport ctl  (output start, pop, clear, input busy, done, ovrn, result, full, nempty, ovfl,
                head);
  modport cvt  (input start, output busy, done, ovrn, result);
  modport fifo (input done, result, pop, clear, output full, nempty, ovfl, head);
endinterface

// file: acf_conv.sv
`timescale 1ns/10ps
module acf_conv
  import acf_pkg::*;
#(
  parameter int unsigned CYC = CONV_CYC
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control side
  acf_if.cvt                    lk,
  // Converter pins
  input  wire logic [RES_W-1:0] adc_data,
  output logic                  adc_start
);
  acf_cv_t     st_r;   // Conversion state
  logic [8:0]  cnt_r;  // Cycles left in conversion

  assign lk.busy = (st_r == CV_BUSY);

  // Conversion sequencer; a start while busy is refused, the running one finishes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= CV_IDLE;
      cnt_r     <= 9'h000;
      adc_start <= 1'b0;
      lk.done   <= 1'b0;
      lk.ovrn   <= 1'b0;
      lk.result <= 12'h000;
    end else begin
      adc_start <= 1'b0;
      lk.done   <= 1'b0;
      lk.ovrn   <= lk.start && (st_r == CV_BUSY);
      case (st_r)
        CV_IDLE: begin
          if (lk.start) begin
            st_r      <= CV_BUSY;
            cnt_r     <= 9'(CYC - 1);
            adc_start <= 1'b1;
          end
        end
        CV_BUSY: begin
          if (cnt_r == 9'h000) begin
            // Capture at end of cycle; push happens on the done pulse
            st_r      <= CV_IDLE;
            lk.done   <= 1'b1;
            lk.result <= adc_data;
          end else begin
            cnt_r <= cnt_r - 9'h001;
          end
        end
        default: st_r <= CV_IDLE;
      endcase
    end
  end
endmodule

// file: acf_fifo.sv
`timescale 1ns/10ps
module acf_fifo
  import acf_pkg::*;
#(
  parameter int unsigned W     = RES_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control side
  acf_if.fifo       lk
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];  // Result storage
  logic [AW-1:0] wp_r;          // Write index
  logic [AW-1:0] rp_r;          // Read index
  logic [AW:0]   cnt_r;         // Entries held
  logic          push;          // Accepted write
  logic          pop;           // Accepted read

  assign lk.full   = (cnt_r == (AW+1)'(DEPTH));
  assign lk.nempty = (cnt_r != '0);
  assign lk.head   = mem_r[rp_r];
  // A pop on full frees the slot the same cycle, so that result is kept
  assign pop  = lk.pop && lk.nempty;
  assign push = lk.done && (!lk.full || pop);
  assign lk.ovfl = lk.done && lk.full && !pop;

  // Storage write
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wp_r] <= lk.result;
    end
  end

  // Pointers and count; flush wins over a push in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (lk.clear) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: acf_top.sv
`timescale 1ns/10ps
// Behaviour
// - Soft convert write starts one conversion
// - Low pulse on ext_convert_n starts conversion
// - Finished result pushed into FIFO automatically
// - Status bit 13 shows FIFO not empty
// - FIFO data read pops; empties flag
// - Not-empty sets about 5 us after start
// - 256 entries; full drop sets overflow low
// - Start during conversion sets overrun low
// - Unipolar results straight binary 0..4095
// - Bipolar results two's complement -2048..2047
// - Clear resets flags, FIFO, done
// - Counters reload at end; retriggerable
// - Entry bits 7:4 channel, 3:1 gain; load applies
// - Interval counter paces every N counts, 2..65536
// - Sample counter stops pacing at count
// - Start strobe or ext_trigger_n triggers acquisition
module acf_top
  import acf_pkg::*;
#(
  parameter int unsigned DIV_10K_P = DIV_10K,
  parameter int unsigned DIV_1K_P  = DIV_1K,
  parameter int unsigned DIV_100_P = DIV_100
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // External pins, asynchronous
  input  wire logic             ext_convert_n,
  input  wire logic             ext_trigger_n,
  input  wire logic             ext_timebase,
  // Converter
  input  wire logic [RES_W-1:0] adc_data,
  output logic                  adc_start,
  // Active channel and gain
  output logic      [3:0]       chan_sel,
  output logic      [2:0]       gain_sel
);
  acf_if lk ();

  // Interval count N in 17 bits, where a zero load means 65536
  function automatic logic [16:0] n16(input logic [15:0] v);
    n16 = (v == 16'h0000) ? 17'h10000 : {1'b0, v};
  endfunction

  // Bus-clock cycles per timebase count; zero marks the external source
  function automatic logic [19:0] tb_div(input logic [3:0] src);
    case (src)
      SRC_5M:   tb_div = 20'(DIV_5M);
      SRC_1M:   tb_div = 20'(DIV_1M);
      SRC_100K: tb_div = 20'(DIV_100K);
      SRC_10K:  tb_div = 20'(DIV_10K_P);
      SRC_1K:   tb_div = 20'(DIV_1K_P);
      SRC_100:  tb_div = 20'(DIV_100_P);
      default:  tb_div = 20'h00000;
    endcase
  endfunction

  logic [3:0]  ctrl_r;        // Mode control bits
  logic [7:0]  chg_entry_r;   // Staged channel and gain
  logic [15:0] iv_mode_r;     // Interval mode word
  logic [15:0] iv_load_r;     // Interval load value
  logic [31:0] samp_r;        // Programmed sample count
  logic        ovfl_n_r;      // Overflow flag, low on error
  logic        ovrn_n_r;      // Overrun flag, low on error
  logic        done_r;        // Acquisition complete
  logic [2:0]  s1_r, s2_r, s3_r, pin_r, pin_d_r; // Pin sync chain
  acf_aq_t     aq_r;          // Acquisition state
  logic [19:0] pre_r;         // Timebase prescaler
  logic [16:0] iv_r;          // Interval countdown
  logic [31:0] left_r;        // Samples still to take

  // APB phases; the slave never stretches, so access is one cycle
  logic setup, wr, rd;
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite;
  assign rd    = psel && penable && !pwrite;

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] o, input logic w);
    wr_at = w && (a == o);
  endfunction

  logic clr, soft_conv, acq_strobe;
  assign clr        = wr_at(paddr, OFS_CLEAR, wr);
  assign soft_conv  = wr_at(paddr, OFS_SOFT_CONV, wr);
  assign acq_strobe = wr_at(paddr, OFS_ACQ_START, wr);

  // Filtered pin edges: index 0 convert, 1 trigger, 2 timebase
  logic conv_fall, trig_fall, tb_rise;
  assign conv_fall = pin_d_r[0] && !pin_r[0];
  assign trig_fall = pin_d_r[1] && !pin_r[1];
  assign tb_rise   = !pin_d_r[2] && pin_r[2];

  // Three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= 3'h3;
      s2_r    <= 3'h3;
      s3_r    <= 3'h3;
      pin_r   <= 3'h3;
      pin_d_r <= 3'h3;
    end else begin
      s1_r    <= {ext_timebase, ext_trigger_n, ext_convert_n};
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      pin_r   <= (pin_r & (s2_r ^ s3_r)) | (s2_r & ~(s2_r ^ s3_r));
      pin_d_r <= pin_r;
    end
  end

  // Timebase and pacing; running only while acquiring
  logic        ext_pace, tick, pace, trig, last;
  logic [19:0] div;
  assign div      = tb_div(iv_mode_r[SRC_LO+3:SRC_LO]);
  assign ext_pace = ctrl_r[CTRL_EXT_PACE];
  assign tick     = (div == 20'h00000) ? tb_rise : (pre_r == div - 20'h00001);
  assign pace     = (aq_r == AQ_RUN) &&
                    (ext_pace ? conv_fall : (tick && iv_r == 17'h00001));
  assign trig     = (aq_r == AQ_IDLE) && ctrl_r[CTRL_ACQ_EN] && (acq_strobe || trig_fall);
  assign last     = pace && (left_r == 32'h0000_0001);

  // Conversion start sources; pin pulses pace only while acquiring
  assign lk.start = soft_conv || pace ||
                    (conv_fall && !(ext_pace && aq_r == AQ_RUN));
  assign lk.pop   = rd && (paddr == OFS_FIFO);
  assign lk.clear = clr;

  // Acquisition sequencer; counters reload so the next trigger reruns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aq_r   <= AQ_IDLE;
      pre_r  <= 20'h00000;
      iv_r   <= 17'h00001;
      left_r <= 32'h0000_0000;
    end else begin
      case (aq_r)
        AQ_IDLE: begin
          pre_r <= 20'h00000;
          iv_r  <= 17'h00001;
          if (trig) begin
            aq_r   <= AQ_RUN;
            left_r <= ctrl_r[CTRL_CNT32] ? samp_r : {15'h0000, n16(samp_r[15:0])};
          end
        end
        AQ_RUN: begin
          if (div != 20'h00000) begin
            pre_r <= tick ? 20'h00000 : pre_r + 20'h00001;
          end
          if (tick && !ext_pace) begin
            iv_r <= (iv_r == 17'h00001) ? n16(iv_load_r) : iv_r - 17'h00001;
          end
          if (pace) begin
            left_r <= left_r - 32'h0000_0001;
          end
          if (last) begin
            aq_r <= AQ_IDLE;
          end
        end
        default: aq_r <= AQ_IDLE;
      endcase
    end
  end

  // Error and done flags; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovfl_n_r <= 1'b1;
      ovrn_n_r <= 1'b1;
      done_r   <= 1'b0;
    end else begin
      if (lk.ovfl) begin
        ovfl_n_r <= 1'b0;
      end else if (clr) begin
        ovfl_n_r <= 1'b1;
      end
      if (lk.ovrn) begin
        ovrn_n_r <= 1'b0;
      end else if (clr) begin
        ovrn_n_r <= 1'b1;
      end
      if (last) begin
        done_r <= 1'b1;
      end else if (clr) begin
        done_r <= 1'b0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= CTRL_RST;
      chg_entry_r <= 8'h00;
      iv_mode_r   <= IV_MODE_RST;
      iv_load_r   <= IV_LOAD_RST;
      samp_r      <= SAMP_RST;
      chan_sel    <= 4'h0;
      gain_sel    <= 3'h0;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL:      ctrl_r      <= pwdata[3:0];
        OFS_CHG_ENTRY: chg_entry_r <= pwdata[7:0];
        OFS_IV_MODE:   iv_mode_r   <= pwdata[15:0];
        OFS_IV_LOAD:   iv_load_r   <= pwdata[15:0];
        OFS_SAMP_CNT:  samp_r      <= pwdata;
        OFS_CHG_LOAD: begin
          chan_sel <= chg_entry_r[CHG_CHAN_LO+:4];
          gain_sel <= chg_entry_r[CHG_GAIN_LO+:3];
        end
        OFS_CHG_CLEAR: begin
          chg_entry_r <= 8'h00;
          chan_sel    <= 4'h0;
          gain_sel    <= 3'h0;
        end
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle
  logic [15:0] status;
  logic [31:0] fifo_word;
  assign status = {ovrn_n_r, ovfl_n_r, lk.nempty, 2'b00, (aq_r == AQ_RUN),
                   lk.busy, done_r, 8'h00};
  assign fifo_word = ctrl_r[CTRL_UNIP] ? {20'h00000, lk.head}
                   : {{21{~lk.head[RES_W-1]}}, lk.head[RES_W-2:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= (paddr > OFS_SAMP_CNT) || (paddr[1:0] != 2'b00) ||
                   (!pwrite && (paddr == OFS_SOFT_CONV || paddr == OFS_CLEAR ||
                                paddr == OFS_CHG_LOAD || paddr == OFS_CHG_CLEAR ||
                                paddr == OFS_ACQ_START)) ||
                   (pwrite && (paddr == OFS_STATUS || paddr == OFS_FIFO));
        case (paddr)
          OFS_CTRL:      prdata <= {28'h0000000, ctrl_r};
          OFS_STATUS:    prdata <= {16'h0000, status};
          OFS_FIFO:      prdata <= fifo_word;
          OFS_CHG_ENTRY: prdata <= {24'h000000, chg_entry_r};
          OFS_IV_MODE:   prdata <= {16'h0000, iv_mode_r};
          OFS_IV_LOAD:   prdata <= {16'h0000, iv_load_r};
          OFS_SAMP_CNT:  prdata <= samp_r;
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  acf_conv u_conv (
    .pclk      (pclk),
    .presetn   (presetn),
    .lk        (lk.cvt),
    .adc_data  (adc_data),
    .adc_start (adc_start)
  );

  acf_fifo u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .lk      (lk.fifo)
  );

  // Checks
  sequence s_idle_start;
    lk.start && !lk.busy && !lk.nempty;
  endsequence
  sequence s_quiet;
    !lk.clear && !lk.pop;
  endsequence

  a_soft_start: assert property (@(posedge pclk) disable iff (!presetn)
    soft_conv && !lk.busy |=> adc_start) else $error("soft convert did not start");
  a_pin_start: assert property (@(posedge pclk) disable iff (!presetn)
    conv_fall && aq_r == AQ_IDLE && !lk.busy |=> adc_start)
    else $error("pin convert did not start");
  a_ready_5us: assert property (@(posedge pclk) disable iff (!presetn)
    s_idle_start ##1 s_quiet [*8] |-> ##[243:244] lk.nempty)
    else $error("result not ready near 5 us");
  a_empty_pop: assert property (@(posedge pclk) disable iff (!presetn)
    lk.pop && u_fifo.cnt_r == 9'h001 && !lk.done |=> !lk.nempty)
    else $error("last pop did not clear not-empty");
  a_ovfl_flag: assert property (@(posedge pclk) disable iff (!presetn)
    lk.done && lk.full && !lk.pop && !lk.clear |=> !ovfl_n_r && lk.full)
    else $error("overflow not flagged");
  a_ovrn_keep: assert property (@(posedge pclk) disable iff (!presetn)
    lk.start && lk.busy && u_conv.cnt_r != 9'h000 |=> lk.busy ##1 !ovrn_n_r)
    else $error("overrun not flagged or busy lost");
  a_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
    clr && !lk.done && !lk.ovrn && !last |=> ovfl_n_r && ovrn_n_r && !done_r && !lk.nempty)
    else $error("clear incomplete");
  a_bip_sign: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr == OFS_FIFO && !ctrl_r[CTRL_UNIP] |=> prdata[31:11] == {21{prdata[11]}})
    else $error("bipolar word not sign-extended");
  a_unip_range: assert property (@(posedge pclk) disable iff (!presetn)
    setup && paddr == OFS_FIFO && ctrl_r[CTRL_UNIP] |=> prdata[31:12] == 20'h00000)
    else $error("unipolar word out of range");
  a_stop_count: assert property (@(posedge pclk) disable iff (!presetn)
    last |=> aq_r == AQ_IDLE && done_r ##1 iv_r == 17'h00001)
    else $error("acquisition did not stop and reload");
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb;
  import acf_pkg::*;
  // Status masks: done, acquiring, not empty, overflow_n, overrun_n
  localparam logic [31:0] DN = 32'h0000_0100;
  localparam logic [31:0] RN = 32'h0000_0400;
  localparam logic [31:0] NE = 32'h0000_2000;
  localparam logic [31:0] OV = 32'h0000_4000;
  localparam logic [31:0] OR = 32'h0000_8000;
  // Bus, pins and converter stimulus
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        ext_convert_n, ext_trigger_n, ext_timebase;
  logic [11:0] adc_data;
  logic        adc_start;
  logic [3:0]  chan_sel;
  logic [2:0]  gain_sel;
  // Last read word and error, run tallies
  logic [31:0] rd;
  logic        er;
  int          n_fail, comparisons;

  // Free-running bus clock, 20 ns
  always #10 pclk = ~pclk;

  // Small 100 Hz divisor keeps paced runs short
  acf_top #(.DIV_100_P(20)) acf_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_convert_n(ext_convert_n), .ext_trigger_n(ext_trigger_n),
    .ext_timebase(ext_timebase), .adc_data(adc_data), .adc_start(adc_start),
    .chan_sel(chan_sel), .gain_sel(gain_sel));

  // Single comparison point
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits on pready as long as it takes, the watchdog bounds it
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Masked status compare
  task sts(input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & m, exp);
  endtask

  // Pop until empty, every entry must carry the paced value
  task drain(output int n);
    n = 0;
    apb(1'b0, OFS_STATUS, 32'h0);
    while (rd[13] === 1'b1 && n < 300) begin
      apb(1'b0, OFS_FIFO, 32'h0);
      chk(rd, 32'h0000_0123);
      n++;
      apb(1'b0, OFS_STATUS, 32'h0);
    end
  endtask

  // Reset flags, unmapped read, soft conversion timing and unipolar data
  task t_soft;
    sts(DN | NE | OV | OR, OV | OR);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    adc_data <= 12'hABC;
    apb(1'b1, OFS_CLEAR, 32'h0);
    apb(1'b1, OFS_SOFT_CONV, 32'h0);
    @(negedge pclk);
    chk({31'h0, adc_start}, 32'h1);
    repeat (200) @(posedge pclk);
    sts(NE, 32'h0);
    repeat (60) @(posedge pclk);
    sts(NE, NE);
    apb(1'b0, OFS_FIFO, 32'h0);
    chk(rd, 32'h0000_0ABC);
    sts(NE, 32'h0);
    $display("t_soft done");
  endtask

  // Second start while busy: flag drops, first result survives, bipolar minimum
  task t_overrun;
    apb(1'b1, OFS_CTRL, 32'h0);
    adc_data <= 12'h000;
    apb(1'b1, OFS_SOFT_CONV, 32'h0);
    apb(1'b1, OFS_SOFT_CONV, 32'h0);
    repeat (2) @(posedge pclk);
    sts(OR | NE, 32'h0);
    repeat (260) @(posedge pclk);
    apb(1'b0, OFS_FIFO, 32'h0);
    chk(rd, 32'hFFFF_F800);
    sts(NE, 32'h0);
    apb(1'b1, OFS_CLEAR, 32'h0);
    sts(OR, OR);
    $display("t_overrun done");
  endtask

  // Pin-started conversion, bipolar maximum
  task t_ext;
    adc_data <= 12'hFFF;
    @(posedge pclk);
    ext_convert_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_convert_n <= 1'b1;
    repeat (270) @(posedge pclk);
    sts(NE, NE);
    apb(1'b0, OFS_FIFO, 32'h0);
    chk(rd, 32'h0000_07FF);
    $display("t_ext done");
  endtask

  // Entry waits for load before reaching the outputs
  task t_chg;
    apb(1'b1, OFS_CHG_CLEAR, 32'h0);
    apb(1'b1, OFS_CHG_ENTRY, 32'h0000_005C);
    apb(1'b1, OFS_CHG_LOAD, 32'h0);
    apb(1'b1, OFS_CHG_ENTRY, 32'h0000_00A6);
    repeat (2) @(posedge pclk);
    chk({25'h0, chan_sel, gain_sel}, 32'h0000_002E);
    apb(1'b1, OFS_CHG_LOAD, 32'h0);
    repeat (2) @(posedge pclk);
    chk({25'h0, chan_sel, gain_sel}, 32'h0000_0053);
    apb(1'b0, OFS_CHG_ENTRY, 32'h0);
    chk(rd, 32'h0000_00A6);
    $display("t_chg done");
  endtask

  // Two-sample paced run by pin trigger, then retrigger by strobe
  task t_acq;
    int n;
    apb(1'b1, OFS_IV_MODE, 32'h0000_8F25);
    apb(1'b1, OFS_IV_LOAD, 32'h0000_0014);
    apb(1'b1, OFS_SAMP_CNT, 32'h0000_0002);
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    adc_data <= 12'h123;
    apb(1'b1, OFS_CLEAR, 32'h0);
    @(posedge pclk);
    ext_trigger_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_trigger_n <= 1'b1;
    repeat (1000) @(posedge pclk);
    sts(DN | RN | NE, DN | NE);
    drain(n);
    chk(32'(n), 32'h2);
    apb(1'b1, OFS_ACQ_START, 32'h0);
    repeat (1000) @(posedge pclk);
    drain(n);
    chk(32'(n), 32'h2);
    apb(1'b1, OFS_CLEAR, 32'h0);
    sts(DN, 32'h0);
    $display("t_acq done");
  endtask

  // Pin-paced run on the 32-bit sample count: three pin pulses give three results
  task t_pace;
    int n;
    apb(1'b1, OFS_SAMP_CNT, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, 32'h0000_000F);
    apb(1'b1, OFS_CLEAR, 32'h0);
    apb(1'b1, OFS_ACQ_START, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ext_convert_n <= 1'b0;
      repeat (4) @(posedge pclk);
      ext_convert_n <= 1'b1;
      repeat (300) @(posedge pclk);
    end
    sts(DN | RN | NE, DN | NE);
    drain(n);
    chk(32'(n), 32'h3);
    apb(1'b1, OFS_CLEAR, 32'h0);
    $display("t_pace done");
  endtask

  // Fill 256, one more is dropped, clear empties and restores the flag
  task t_ovfl;
    apb(1'b1, OFS_CTRL, 32'h0);
    adc_data <= 12'h800;
    for (int i = 0; i < 257; i++) begin
      if (i == 256) begin
        sts(OV | NE, OV | NE);
      end
      apb(1'b1, OFS_SOFT_CONV, 32'h0);
      repeat (260) @(posedge pclk);
    end
    sts(OV | NE, NE);
    apb(1'b1, OFS_CLEAR, 32'h0);
    sts(OV | NE, OV);
    $display("t_ovfl done");
  endtask

  // Verdict and end of run
  task results;
    $display("Counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the full run needs about 72k cycles
  initial begin
    repeat (90000) @(posedge pclk);
    n_fail++;
    results;
  end

  // Main sequence; timebase pin is unused by the chosen source
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_convert_n = 1'b1;
    ext_trigger_n = 1'b1;
    ext_timebase = 1'b0;
    adc_data = 12'h000;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_soft;
    t_overrun;
    t_ext;
    t_chg;
    t_acq;
    t_pace;
    t_ovfl;
    results;
  end
endmodule
